// *** src/scp_cfg.svh ***
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
// ----------------------------------------
// serial frame layout
// ----------------------------------------
`define SCP_FRAME_LAST 5'h17
`define SCP_HDR_LAST   5'h0F
`define SCP_RD_FIRST   5'h10
`define SCP_RW_POS     23
`define SCP_HDR_RW_POS 15
`define SCP_ZERO_HI    22
`define SCP_ZERO_LO    20
`define SCP_ADDR_HI    19
`define SCP_ADDR_LO    8
// ----------------------------------------
// serial register addresses
// ----------------------------------------
`define SCP_SA_RESET 12'h000
`define SCP_SA_PWR   12'h008
`define SCP_SA_LANE  12'h009
`define SCP_SA_MASK  12'h00D
`define SCP_SA_PIN   12'h00E
`define SCP_SA_AVG   12'h024
`define SCP_RST_VAL  8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define SCP_SOFT_RST    0
`define SCP_PWR_GLOBAL  0
`define SCP_PWR_B       1
`define SCP_PWR_A       2
`define SCP_PWR_REFAMP  4
`define SCP_PWR_CLKBUF  5
`define SCP_MASK_BG     1
`define SCP_MASK_REFAMP 2
`define SCP_MASK_CLKBUF 3
`define SCP_PIN_SYNCEN  7
`define SCP_PIN_SPISYNC 6
`define SCP_PIN_SPIEN   5
`define SCP_PIN_REFCTL  3
`define SCP_PIN_REF_HI  2
`define SCP_PIN_REF_LO  1
`define SCP_PIN_SECLK   0
`define SCP_AVG_EN      5
`define SCP_AVG_MUX_HI  4
`define SCP_AVG_MUX_LO  3
// ----------------------------------------
// reference pin codes
// ----------------------------------------
`define SCP_REFPIN_SE   2'h3
`define SCP_REF_INT     2'h0
// ----------------------------------------
// apb byte offsets
// ----------------------------------------
`define SCP_APB_LAST_REG 3'h4
`define SCP_APB_STATUS   12'h014
// ----------------------------------------
// widths and timing
// ----------------------------------------
`define SCP_RAW_W       18
`define SCP_OUT_W       20
`define SCP_CLK_NS      10
`define SCP_SMP_IDLE_NS 4000
`define SCP_SMP_IDLE_CYC ((`SCP_SMP_IDLE_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`endif

// *** src/scp_pkg.sv ***
`include "scp_cfg.svh"
package scp_pkg;
  // serial frame phase
  typedef enum logic [1:0] {
    scp_ph_idle  = 2'b00,
    scp_ph_hdr   = 2'b01,
    scp_ph_wdata = 2'b10,
    scp_ph_rdata = 2'b11
  } scp_phase_t;
  typedef logic [7:0]              scp_byte_t;   // one register
  typedef logic [`SCP_RAW_W-1:0]   scp_raw_t;    // converter word
  typedef logic [`SCP_OUT_W-1:0]   scp_sample_t; // output word
endpackage

// *** src/scp_chan_avg.sv ***
`include "scp_cfg.svh"
module scp_chan_avg #(
  parameter int W_IN  = `SCP_RAW_W,
  parameter int W_OUT = `SCP_OUT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [W_IN-1:0]  chan_a,
  input  wire logic [W_IN-1:0]  chan_b,
  input  wire logic             in_valid,
  input  wire logic             avg_en,
  input  wire logic             to_decim,
  output logic      [W_OUT-1:0] out_a,
  output logic      [W_OUT-1:0] out_b,
  output logic      [W_OUT-1:0] decim_a,
  output logic      [W_OUT-1:0] decim_b,
  output logic                  out_valid
);
  // ----------------------------------------
  // combine and route
  // ----------------------------------------
  // sign-extended sum keeps the extra bit of resolution
  wire [W_IN:0]    sum     = {chan_a[W_IN-1], chan_a} + {chan_b[W_IN-1], chan_b};
  wire [W_OUT-1:0] avg_w   = {sum, {(W_OUT-W_IN-1){1'b0}}};
  wire [W_OUT-1:0] a_w     = {chan_a, {(W_OUT-W_IN){1'b0}}};
  wire [W_OUT-1:0] b_w     = {chan_b, {(W_OUT-W_IN){1'b0}}};
  wire             avg_out = avg_en && !to_decim;
  wire             avg_dec = avg_en && to_decim;

  // outputs are held between valid samples
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_a     <= '0;
      out_b     <= '0;
      decim_a   <= '0;
      decim_b   <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_a   <= avg_out ? avg_w : a_w;
        out_b   <= b_w;
        decim_a <= avg_dec ? avg_w : a_w;
        decim_b <= b_w;
      end
    end
  end

  AST_AVG_ON_A: assert property (@(posedge clk_sys) disable iff (!reset_n)
    in_valid && avg_out |=> out_a == $past(avg_w))
    else $error("average missing on channel A output");
  AST_AVG_TO_DECIM: assert property (@(posedge clk_sys) disable iff (!reset_n)
    in_valid && avg_dec |=> decim_a == $past(avg_w) && out_a == $past(a_w))
    else $error("average not routed to decimator");
endmodule

// *** src/scp_spi_config_port.sv ***
// What this block does
// - global power-down from register bit or pin
// - power-down pin active high, pulled low
// - global power-down stops both channels always
// - power-down acts only with sampling clock running
// - unused lane drivers powered down by register
// - averaging sums both channels into one
// - average goes to A outputs or decimators
// - defaults after reset, pins still work
// - bits shift in only while select low
// - data sampled on each serial clock rise
// - write frame committed on its 24th rise, reserved bits zero
// - partial trailing bits dropped at deselect
// - back-to-back frames each handled alone
// - serial clock up to 12 MHz, any duty
// - eight write data bits, msb first
// - read header blocks serial register writes, apb writes still land
// - read data driven, changed on falls
// - global bit powers down, mask picks blocks
// - bandgap mask has inverted sense
// - control bit picks pin power-down or sync
`include "scp_cfg.svh"
module scp_spi_config_port #(
  parameter int unsigned SMP_IDLE_CYC = `SCP_SMP_IDLE_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               serial_select_n,
  input  wire logic               serial_clk,
  input  wire logic               serial_data_in,
  output logic                    serial_data_out,
  output logic                    serial_data_oe,
  input  wire logic               powerdown_sync_pin,
  input  wire logic [1:0]         reference_select_pin,
  input  wire logic               sample_clk_pin,
  input  wire scp_pkg::scp_raw_t  chan_a_data,
  input  wire scp_pkg::scp_raw_t  chan_b_data,
  input  wire logic               sample_valid,
  output scp_pkg::scp_sample_t    out_a_data,
  output scp_pkg::scp_sample_t    out_b_data,
  output scp_pkg::scp_sample_t    decim_a_data,
  output scp_pkg::scp_sample_t    decim_b_data,
  output logic                    out_valid,
  output logic                    pd_chan_a,
  output logic                    pd_chan_b,
  output logic                    pd_refamp,
  output logic                    pd_clkbuf,
  output logic                    pd_bandgap,
  output logic      [5:0]         pd_lanes,
  output logic      [1:0]         ref_select,
  output logic                    se_clock_sel,
  output logic                    sync_pulse
);
  import scp_pkg::*;

  localparam int NREG = 5;
  // serial address of each stored register, apb index order
  localparam logic [11:0] REG_SADDR [NREG] = '{
    `SCP_SA_PWR, `SCP_SA_LANE, `SCP_SA_MASK, `SCP_SA_PIN, `SCP_SA_AVG};
  localparam logic [15:0] IDLE_LIM = 16'(SMP_IDLE_CYC);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire  [6:0] pins_raw = {reference_select_pin, sample_clk_pin, powerdown_sync_pin,
                          serial_data_in, serial_clk, serial_select_n};
  logic [6:0] pin_meta;  // first stage, read by pin_sync only
  logic [6:0] pin_sync;  // second stage
  logic       sclk_prev; // for serial clock edges
  logic       smp_prev;  // for sampling clock edges
  logic       pdp_prev;  // for pin sync edge

  // every pin crosses two flops before logic looks at it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta  <= 7'h01;
      pin_sync  <= 7'h01;
      sclk_prev <= 1'b0;
      smp_prev  <= 1'b0;
      pdp_prev  <= 1'b0;
    end else begin
      pin_meta  <= pins_raw;
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync[1];
      smp_prev  <= pin_sync[4];
      pdp_prev  <= pin_sync[3];
    end
  end

  wire       sel_s     = pin_sync[0];
  wire       sclk_s    = pin_sync[1];
  wire       sdi_s     = pin_sync[2];
  wire       pdpin_s   = pin_sync[3];
  wire       smp_s     = pin_sync[4];
  wire [1:0] refpin_s  = pin_sync[6:5];
  // edges seen with a few cycles of lag; at 12 MHz a half period
  // is four system cycles, enough for the sync delay
  wire       sclk_rise = sclk_s && !sclk_prev;
  wire       sclk_fall = !sclk_s && sclk_prev;

  // ----------------------------------------
  // serial frame engine
  // ----------------------------------------
  scp_phase_t phase;      // where in the frame we are
  scp_phase_t next_phase;
  logic [4:0]  bit_cnt;   // rising edges in current frame
  logic [22:0] shift;     // bits gathered so far
  scp_byte_t   rd_shift;  // readback byte being sent
  scp_byte_t   regs [NREG];          // stored registers
  logic [7:0]  rd_chain [NREG+1];    // serial readback select chain
  logic [7:0]  apb_chain [NREG+1];   // apb readback select chain

  wire        shift_rise = !sel_s && sclk_rise;
  wire [23:0] frame      = {shift, sdi_s};
  wire        hdr_done   = shift_rise && bit_cnt == `SCP_HDR_LAST;
  wire        last_bit   = shift_rise && bit_cnt == `SCP_FRAME_LAST;
  wire        hdr_zero   = frame[`SCP_ZERO_HI:`SCP_ZERO_LO] == 3'h0;
  // the read phase is the only one other than write at the last bit
  wire        commit_wr  = last_bit && phase == scp_ph_wdata && hdr_zero;
  wire [11:0] wr_addr    = frame[`SCP_ADDR_HI:`SCP_ADDR_LO];
  wire [7:0]  wr_data    = frame[7:0];
  wire [11:0] hdr_addr   = frame[11:0];
  wire        hdr_read   = frame[`SCP_HDR_RW_POS];
  wire        rd_launch  = phase == scp_ph_rdata && sclk_fall && !sel_s &&
                           bit_cnt >= `SCP_RD_FIRST;

  // phase moves with the frame; deselect always returns to idle
  always_comb begin
    next_phase = phase;
    if (sel_s) begin
      next_phase = scp_ph_idle;
    end else begin
      unique case (phase)
        scp_ph_idle:  next_phase = scp_ph_hdr;
        scp_ph_hdr: begin
          if (hdr_done) begin
            next_phase = hdr_read ? scp_ph_rdata : scp_ph_wdata;
          end
        end
        scp_ph_wdata, scp_ph_rdata: begin
          if (last_bit) begin
            next_phase = scp_ph_hdr;
          end
        end
      endcase
    end
  end

  // bit counter and input shifter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase   <= scp_ph_idle;
      bit_cnt <= 5'h00;
      shift   <= '0;
    end else begin
      phase <= next_phase;
      if (sel_s) begin
        bit_cnt <= 5'h00;
      end else if (shift_rise) begin
        shift   <= frame[22:0];
        bit_cnt <= last_bit ? 5'h00 : bit_cnt + 5'h01;
      end
    end
  end

  // readback driver: launch on falls, release at frame end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_oe  <= 1'b0;
      serial_data_out <= 1'b0;
      rd_shift        <= `SCP_RST_VAL;
    end else begin
      if (hdr_done) begin
        rd_shift <= rd_chain[NREG];
      end else if (rd_launch) begin
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
      if (sel_s || last_bit) begin
        serial_data_oe <= 1'b0;
      end else if (rd_launch) begin
        serial_data_oe  <= 1'b1;
        serial_data_out <= rd_shift[7];
      end
    end
  end

  // ----------------------------------------
  // register file, serial and apb writers
  // ----------------------------------------
  wire [2:0] apb_idx   = paddr[4:2];
  wire       apb_in_rf = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 &&
                         apb_idx <= `SCP_APB_LAST_REG;
  wire       apb_stat  = paddr == `SCP_APB_STATUS;
  wire       apb_wr    = psel && penable && pwrite && apb_in_rf;
  // soft reset returns every register to its default
  wire       soft_rst  = commit_wr && wr_addr == `SCP_SA_RESET && wr_data[`SCP_SOFT_RST];

  assign rd_chain[0]  = 8'h00;
  assign apb_chain[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      wire spi_hit = commit_wr && wr_addr == REG_SADDR[gi];
      wire apb_hit = apb_wr && apb_idx == 3'(gi);
      // serial wins over apb when both land on one cycle
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          regs[gi] <= `SCP_RST_VAL;
        end else if (soft_rst) begin
          regs[gi] <= `SCP_RST_VAL;
        end else if (spi_hit) begin
          regs[gi] <= wr_data;
        end else if (apb_hit) begin
          regs[gi] <= pwdata[7:0];
        end
      end
      assign rd_chain[gi+1]  = rd_chain[gi] |
                               (hdr_addr == REG_SADDR[gi] ? regs[gi] : 8'h00);
      assign apb_chain[gi+1] = apb_chain[gi] |
                               (apb_idx == 3'(gi) ? regs[gi] : 8'h00);
    end
  endgenerate

  wire [7:0] r_pwr  = regs[0];
  wire [7:0] r_lane = regs[1];
  wire [7:0] r_mask = regs[2];
  wire [7:0] r_pin  = regs[3];
  wire [7:0] r_avg  = regs[4];

  // ----------------------------------------
  // sampling clock presence
  // ----------------------------------------
  logic [15:0] idle_cnt; // cycles since last sampling clock edge
  wire         smp_edge    = smp_s ^ smp_prev;
  wire         clk_running = idle_cnt < IDLE_LIM;

  // saturating count; a stopped clock freezes power state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt <= IDLE_LIM;
    end else if (smp_edge) begin
      idle_cnt <= 16'h0000;
    end else if (clk_running) begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // power-down control
  // ----------------------------------------
  logic glob_active; // global power-down in force
  wire  pin_is_sync = r_pin[`SCP_PIN_SYNCEN];
  wire  pin_pd_req  = pdpin_s && !pin_is_sync;
  wire  next_glob   = r_pwr[`SCP_PWR_GLOBAL] || pin_pd_req;
  wire  next_pd_a   = next_glob || r_pwr[`SCP_PWR_A];
  wire  next_pd_b   = next_glob || r_pwr[`SCP_PWR_B];
  // a set mask bit keeps that block alive in global power-down
  wire  next_refamp = r_pwr[`SCP_PWR_REFAMP] ||
                      (next_glob && !r_mask[`SCP_MASK_REFAMP]);
  wire  next_clkbuf = r_pwr[`SCP_PWR_CLKBUF] ||
                      (next_glob && !r_mask[`SCP_MASK_CLKBUF]);
  // bandgap goes down only when its mask bit is set
  wire  next_bg     = next_glob && r_mask[`SCP_MASK_BG];

  // power state only moves while the sampling clock runs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      glob_active <= 1'b0;
      pd_chan_a   <= 1'b0;
      pd_chan_b   <= 1'b0;
      pd_refamp   <= 1'b0;
      pd_clkbuf   <= 1'b0;
      pd_bandgap  <= 1'b0;
      pd_lanes    <= 6'h00;
    end else if (clk_running) begin
      glob_active <= next_glob;
      pd_chan_a   <= next_pd_a;
      pd_chan_b   <= next_pd_b;
      pd_refamp   <= next_refamp;
      pd_clkbuf   <= next_clkbuf;
      pd_bandgap  <= next_bg;
      pd_lanes    <= r_lane[5:0];
    end
  end

  // ----------------------------------------
  // sync, reference select, apb read
  // ----------------------------------------
  logic spi_sync_prev; // last value of the software sync bit
  wire  spi_sync_tgl = (r_pin[`SCP_PIN_SPISYNC] ^ spi_sync_prev) && r_pin[`SCP_PIN_SPIEN];
  wire  pin_sync_rise = pin_is_sync && pdpin_s && !pdp_prev;
  wire  ref_ctl = r_pin[`SCP_PIN_REFCTL];
  wire  [1:0] ref_from_pin = refpin_s == `SCP_REFPIN_SE ? `SCP_REF_INT : refpin_s;
  wire  [7:0] status = {3'h0, pdpin_s, phase == scp_ph_rdata, phase != scp_ph_idle,
                        clk_running, glob_active};
  wire  [31:0] apb_rd = apb_stat ? {24'h0, status} : {24'h0, apb_chain[NREG]};

  // pin reference choice holds unless software takes over
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      spi_sync_prev <= 1'b0;
      sync_pulse    <= 1'b0;
      ref_select    <= `SCP_REF_INT;
      se_clock_sel  <= 1'b0;
      prdata        <= 32'h0000_0000;
    end else begin
      spi_sync_prev <= r_pin[`SCP_PIN_SPISYNC];
      sync_pulse    <= pin_sync_rise || spi_sync_tgl;
      ref_select    <= ref_ctl ? r_pin[`SCP_PIN_REF_HI:`SCP_PIN_REF_LO] : ref_from_pin;
      se_clock_sel  <= ref_ctl ? r_pin[`SCP_PIN_SECLK] : refpin_s == `SCP_REFPIN_SE;
      if (psel && !penable) begin
        prdata <= apb_rd;
      end
    end
  end

  // zero wait state slave; unmapped access flags an error
  assign pready  = psel && penable;
  assign pslverr = psel && penable && !(apb_in_rf || (apb_stat && !pwrite));

  // ----------------------------------------
  // averaging datapath
  // ----------------------------------------
  scp_chan_avg #(
    .W_IN  (`SCP_RAW_W),
    .W_OUT (`SCP_OUT_W)
  ) u_avg (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .chan_a    (chan_a_data),
    .chan_b    (chan_b_data),
    .in_valid  (sample_valid),
    .avg_en    (r_avg[`SCP_AVG_EN]),
    .to_decim  (r_avg[`SCP_AVG_MUX_HI:`SCP_AVG_MUX_LO] != 2'h0),
    .out_a     (out_a_data),
    .out_b     (out_b_data),
    .decim_a   (decim_a_data),
    .decim_b   (decim_b_data),
    .out_valid (out_valid)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_OE_IN_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
    serial_data_oe |-> phase == scp_ph_rdata && bit_cnt >= `SCP_RD_FIRST)
    else $error("data line driven outside read data bits");
  AST_DESELECT_CLEARS: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sel_s |=> !serial_data_oe && bit_cnt == 5'h00 && phase == scp_ph_idle)
    else $error("deselect did not clear frame state");
  AST_COMMIT_24TH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    commit_wr |-> sclk_rise && bit_cnt == `SCP_FRAME_LAST ##1 bit_cnt == 5'h00)
    else $error("write commit not on 24th rise");
  AST_NO_WR_DESELECT: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sel_s |-> !commit_wr && !shift_rise)
    else $error("bits accepted while deselected");
  AST_READ_BLOCKS_WR: assert property (@(posedge clk_sys) disable iff (!reset_n)
    phase == scp_ph_rdata && !apb_wr |=> $stable(r_pwr) && $stable(r_lane) && $stable(r_mask))
    else $error("write during readback");
  AST_COUNT_ON_RISE: assert property (@(posedge clk_sys) disable iff (!reset_n)
    shift_rise && bit_cnt != `SCP_FRAME_LAST |=> bit_cnt == $past(bit_cnt) + 5'h01)
    else $error("rising edge not counted");
  AST_GLOBAL_BOTH: assert property (@(posedge clk_sys) disable iff (!reset_n)
    glob_active |-> pd_chan_a && pd_chan_b)
    else $error("channel alive in global power-down");
  AST_PD_FROZEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !clk_running |=> $stable(glob_active) && $stable(pd_chan_a))
    else $error("power state moved without sampling clock");
  AST_PD_REQUEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_running && (r_pwr[`SCP_PWR_GLOBAL] || pin_pd_req) |=> glob_active)
    else $error("power-down request ignored");
  AST_BANDGAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
    glob_active && !pd_bandgap |-> !$past(r_mask[`SCP_MASK_BG]) || !$past(clk_running))
    else $error("bandgap kept on with mask set");
endmodule

// *** bench/scp_host.sv ***
// ----------------------------------------
// serial host model: select, clock, data line
// ----------------------------------------
module scp_host (
  input  wire logic clk_sys,
  output logic      serial_select_n,
  output logic      serial_clk,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe,
  output logic      serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_bit; // host's own drive level
  // resolved line: device wins while it drives, else the host's level
  assign serial_data_in = serial_data_oe ? serial_data_out : host_bit;
  initial begin
    serial_select_n = 1'b1;
    serial_clk      = 1'b0;
    host_bit        = 1'b0;
  end
  // idle the link for n system cycles
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one select-low period of n bits, msb first; rd collects read bits
  task send(input logic [47:0] v, input int n, output logic [7:0] rd);
    logic rdg;
    rd = 8'h00;
    @(posedge clk_sys) serial_select_n <= 1'b0;
    tick(3);
    for (int i = 0; i < n; i++) begin
      rdg = v[47 - 24 * (i / 24)] && (i % 24) >= 16;
      // released line shows the inverse so a stale value never passes
      host_bit <= rdg ? ~host_bit : v[47 - i];
      tick(8);
      if (rdg) rd = {rd[6:0], serial_data_in};
      serial_clk <= 1'b1;
      tick(8);
      serial_clk <= 1'b0;
    end
    tick(8);
    serial_select_n <= 1'b1;
    host_bit <= ~host_bit;
    tick(8);
  endtask
endmodule

// *** bench/scp_spi_config_port_test.sv ***
module scp_spi_config_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic smp_run = 1'b1, powerdown_sync_pin = 1'b0, sample_clk_pin = 1'b0, sample_valid = 1'b0;
  logic pready, pslverr, serial_select_n, serial_clk, serial_data_in, serial_data_out;
  logic serial_data_oe, perr, pd_chan_a, pd_chan_b, pd_refamp, pd_clkbuf, pd_bandgap;
  logic out_valid, se_clock_sel, sync_pulse;
  logic [1:0]  reference_select_pin = 2'h0, ref_select;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [5:0]  pd_lanes;
  logic [7:0]  rd;
  scp_raw_t    chan_a_data = '0, chan_b_data = '0;
  scp_sample_t out_a_data, out_b_data, decim_a_data, decim_b_data;
  int          failures = 0, n_tests = 0, n_sync = 0;
  // short idle count keeps the clock-stop case quick
  scp_spi_config_port #(.SMP_IDLE_CYC(40)) dut (
    .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_select_n, .serial_clk, .serial_data_in, .serial_data_out, .serial_data_oe,
    .powerdown_sync_pin, .reference_select_pin, .sample_clk_pin, .chan_a_data,
    .chan_b_data, .sample_valid, .out_a_data, .out_b_data, .decim_a_data, .decim_b_data,
    .out_valid, .pd_chan_a, .pd_chan_b, .pd_refamp, .pd_clkbuf, .pd_bandgap, .pd_lanes,
    .ref_select, .se_clock_sel, .sync_pulse);
  scp_host host (.clk_sys, .serial_select_n, .serial_clk, .serial_data_out, .serial_data_oe,
    .serial_data_in);
  always #5 clk_sys = ~clk_sys;
  // sampling clock only while smp_run is set
  always @(posedge clk_sys) if (smp_run) sample_clk_pin <= ~sample_clk_pin;
  // one-cycle sync pulses counted as they stand at each edge
  always @(posedge clk_sys) if (sync_pulse === 1'b1) n_sync++;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task conclude;
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      failures++;
      conclude();
    end
    rdat = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_apb_pd;
    check(pd_chan_a | pd_lanes, 0, "reset power state");
    apb(1, 12'h000, 32'h1);
    host.tick(5);
    check({pd_chan_a, pd_chan_b, pd_refamp, pd_clkbuf, pd_bandgap}, 5'h1E, "global");
    apb(1, 12'h008, 32'h2);
    host.tick(5);
    check(pd_bandgap, 1, "bandgap mask");
    apb(0, 12'h000, 32'h0);
    check(rdat, 32'h1, "readback");
    apb(1, 12'h000, 32'h11);
    apb(0, 12'h014, 32'h0);
    check(rdat, 32'h3, "status in power-down");
    check(pd_refamp, 1, "refamp held down");
    apb(0, 12'h018, 32'h0);
    check(perr, 1, "unmapped offset");
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h0);
  endtask
  task t_pin;
    smp_run <= 1'b0;
    host.tick(60);
    @(posedge clk_sys) powerdown_sync_pin <= 1'b1;
    host.tick(10);
    check(pd_chan_a, 0, "pin without sampling clock");
    smp_run <= 1'b1;
    host.tick(10);
    check({pd_chan_a, pd_chan_b}, 2'h3, "pin power-down");
    @(posedge clk_sys) powerdown_sync_pin <= 1'b0;
    apb(1, 12'h00C, 32'h80);
    @(posedge clk_sys) powerdown_sync_pin <= 1'b1;
    host.tick(10);
    check(pd_chan_a, 0, "pin set to sync");
    check(n_sync, 1, "pin sync pulse");
    @(posedge clk_sys) powerdown_sync_pin <= 1'b0;
    @(posedge clk_sys) reference_select_pin <= 2'h3;
    host.tick(5);
    check({ref_select, se_clock_sel}, 3'h1, "single-ended clock code");
    @(posedge clk_sys) reference_select_pin <= 2'h2;
    host.tick(5);
    check({ref_select, se_clock_sel}, 3'h4, "external reference code");
    apb(1, 12'h00C, 32'h0B);
    host.tick(3);
    check({ref_select, se_clock_sel}, 3'h3, "software reference choice");
    apb(1, 12'h00C, 32'h0);
  endtask
  task t_serial;
    host.send({24'h00092A, 24'h0}, 24, rd);
    check(pd_lanes, 6'h2A, "serial write");
    host.send({24'h8009FF, 24'h0}, 24, rd);
    check(rd, 8'h2A, "serial read");
    check(pd_lanes, 6'h2A, "read frame wrote");
    host.send({24'h000915, 24'h000907}, 48, rd);
    check(pd_lanes, 6'h07, "two frames");
    host.send({24'h00093F, 24'h0}, 20, rd);
    check(pd_lanes, 6'h07, "partial frame");
    check(serial_data_oe, 0, "line released");
  endtask
  task t_avg(input logic [31:0] mode);
    apb(1, 12'h010, mode);
    @(posedge clk_sys) {chan_a_data, chan_b_data, sample_valid} <= {18'h00100, 18'h00300, 1'b1};
    @(posedge clk_sys) sample_valid <= 1'b0;
    @(negedge clk_sys) check(out_valid, 1, "result valid");
    host.tick(2);
    check(out_valid, 0, "valid is one pulse");
    check(out_a_data, mode == 32'h20 ? 20'h00800 : 20'h00400, "channel A output");
    check(decim_a_data, mode == 32'h28 ? 20'h00800 : 20'h00400, "filter input A");
    check(out_b_data, 20'h00C00, "channel B output");
    check(decim_b_data, 20'h00C00, "filter input B");
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    host.tick(3);
    t_apb_pd();
    t_pin();
    t_serial();
    t_avg(32'h0);
    t_avg(32'h20);
    t_avg(32'h28);
    conclude();
  end
endmodule
